// *** src/catx_defines.svh ***
// Offsets, field positions, reset values and thresholds of the block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CATX_DEFINES_SVH
`define CATX_DEFINES_SVH

`define CATX_AW            8
`define CATX_OFF_STATUS_MSG_IDENTIFIER     8'h00
`define CATX_OFF_RESPONSE_MSG_IDENTIFIER     8'h04
`define CATX_OFF_EVENT_MSG_IDENTIFIER     8'h08
`define CATX_OFF_MASK      8'h0C
`define CATX_OFF_FILT0     8'h10
`define CATX_OFF_FILT1     8'h14
`define CATX_OFF_CTRL      8'h18
`define CATX_OFF_PERIOD    8'h1C
`define CATX_OFF_STATUS    8'h20

`define CATX_CTRL_SCHED_EN 0
`define CATX_CTRL_PAYLOAD  1
`define CATX_CTRL_ACKSEL   2
`define CATX_CTRL_MESSAGE_TYPE_SELECT    3

`define CATX_ID_EXT_BIT    19
`define CATX_ID_CLEAN      32'hFFEB_FFFF
`define CATX_MASK_CLEAN    32'hFFEB_FFF8
`define CATX_RST_WORD      32'h0000_0000
`define CATX_RST_CTRL      4'h0
`define CATX_RST_PERIOD    16'hFFFF

`define CATX_PEND_SCHED    0
`define CATX_PEND_POWER    1
`define CATX_PEND_ACK      2
`define CATX_PEND_OVF      3
`define CATX_PEND_ERR      4
`define CATX_PEND_EVENT    5

`define CATX_WARN_HI       9'h05F
`define CATX_WARN_LO       9'h04F
`define CATX_PASS_HI       9'h07F
`define CATX_PASS_LO       9'h06F

`define CATX_DLC_NONE      4'h0
`define CATX_DLC_ERR       4'h3
`define CATX_DLC_IO        4'h6

`define CATX_RESP_OKAY     2'h0
`define CATX_RESP_SLVERR   2'h2

`endif

// *** src/catx_pkg.sv ***
// Types shared by the identifier and acceptance block.
// Assumes catx_defines.svh is on the include path.
`include "catx_defines.svh"

package catx_pkg;

  typedef enum logic [2:0] {
    KIND_SCHED,
    KIND_POWER,
    KIND_ACK,
    KIND_OVF,
    KIND_ERR,
    KIND_EVENT
  } catx_kind_e;

  typedef enum logic {
    TX_IDLE,
    TX_OFFER
  } catx_txst_e;

  typedef struct packed {
    catx_kind_e  kind;
    logic        ext;
    logic [10:0] sid;
    logic [17:0] eid;
    logic [3:0]  dlc;
    logic [63:0] data;
  } catx_txmsg_s;

  typedef struct packed {
    logic        ext;
    logic [10:0] sid;
    logic [17:0] eid;
  } catx_rxid_s;

  typedef struct packed {
    logic [2:0][31:0] txIdent;
    logic [31:0]      mask;
    logic [1:0][31:0] filt;
    logic [3:0]       ctrl;
    logic [15:0]      period;
    logic [15:0]      timer;
    logic [5:0]       pend;
    logic [1:0]       warnArm;
    logic [1:0]       passArm;
    catx_txst_e       txSt;
    catx_txmsg_s      msg;
    logic             reqAcc;
    logic             cmdAcc;
    logic             awHave;
    logic             wHave;
    logic [7:0]       awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             bValid;
    logic [1:0]       bResp;
    logic             rValid;
    logic [1:0]       rResp;
    logic [31:0]      rData;
  } catx_state_s;

endpackage

// *** src/catx_top.sv ***
// Transmit identifier selection, message scheduling and acceptance filter.
// Assumes an AXI4-Lite master, a CAN engine that takes txMsg on a
// valid/ready handshake, and error counters supplied by the CAN core.
//
// How it works
// R1: scheduled status message uses first identifier
// R2: payload select adds I/O and analog data
// R3: leaving sleep never triggers status message
// R4: ack, overflow, error share second identifier
// R5: ack and overflow carry no data
// R6: error message: three bytes flags, TEC, REC
// R7: one empty status message after power-up
// R8: ack after each processed command, if selected
// R9: overflow message when ack not selected
// R10: error message above 95 or above 127
// R11: warning re-arms at 79 or below
// R12: passive re-arms at 111 or below
// R13: edge/threshold events use third identifier
// R14: wake by enabled input sends event message
// R15: mask bit one compares, zero ignores
// R16: standard frames ignore mask's three low bits
// R17: extended frames force low extended mask bits
// R18: mask frame-select bit gates frame type compare
// R19: request filter and command filter
// R20: accept only full match, drop others silently
// R21: identifier frame-select picks 29 or 11 bits
// R22: message type select masks fourth bit
// R23: filter frame-select picks frame type
// R24: separate re-arm per threshold per counter
`timescale 1ns/1ns
`include "catx_defines.svh"

module catx_top (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Received identifier
  input  wire logic                 rxValid,
  input  wire catx_pkg::catx_rxid_s rxId,
  output logic                      reqAccept,
  output logic                      cmdAccept,
  // Triggers
  input  wire logic                 cmdDone,
  input  wire logic                 rxOverflow,
  input  wire logic                 inputEdge,
  input  wire logic                 analogCross,
  input  wire logic                 wakeUp,
  input  wire logic                 wakeOnChange,
  // Error state and payload sources
  input  wire logic [8:0]           tec,
  input  wire logic [7:0]           rec,
  input  wire logic [7:0]           errorFlagByte,
  input  wire logic [7:0]           gpioValue,
  input  wire logic [39:0]          analogData,
  // Message to the CAN engine
  output logic                      txValid,
  input  wire logic                 txReady,
  output catx_pkg::catx_txmsg_s     txMsg
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rstMeta;
  logic rstSyncB;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta  <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncB <= rstMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] mergeStrb(input logic [31:0] oldW,
                                            input logic [31:0] newW,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = oldW;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newW[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Word: [31:24] std high, [23:16] std low, [15:8] ext mid, [7:0] ext low
  function automatic logic matchId(input catx_pkg::catx_rxid_s id,
                                   input logic [31:0] mw,
                                   input logic [31:0] fw,
                                   input logic        message_type_select);
    logic [10:0] mSid;
    logic [17:0] mEid;
    logic [10:0] fSid;
    logic [17:0] fEid;
    logic        ok;
    mSid = mw[31:21];
    mEid = {mw[17:16], mw[15:8], mw[7:3], 3'h0};  // [R17]
    fSid = fw[31:21];
    fEid = {fw[17:16], fw[15:0]};
    if (message_type_select) begin
      mSid[3] = 1'b0;  // [R22]
    end
    if (!id.ext) begin
      mSid[2:0] = 3'h0;  // [R16]
    end
    ok = ((id.sid ^ fSid) & mSid) == 11'h000;  // [R15]
    if (id.ext) begin
      ok = ok && (((id.eid ^ fEid) & mEid) == 18'h00000);  // [R15]
    end
    if (mw[`CATX_ID_EXT_BIT]) begin
      ok = ok && (id.ext == fw[`CATX_ID_EXT_BIT]);  // [R18] [R23]
    end
    return ok;  // [R20]
  endfunction

  function automatic catx_pkg::catx_txmsg_s buildMsg(
      input catx_pkg::catx_kind_e kind,
      input logic [31:0]          iw,
      input logic [3:0]           dlc,
      input logic [63:0]          data);
    catx_pkg::catx_txmsg_s m;
    m.kind = kind;
    m.ext  = iw[`CATX_ID_EXT_BIT];  // [R21]
    m.sid  = iw[31:21];
    m.eid  = {iw[17:16], iw[15:0]};
    m.dlc  = dlc;
    m.data = data;
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  catx_pkg::catx_state_s s;
  catx_pkg::catx_state_s n;
  logic [5:0]            setV;
  logic [5:0]            clrV;
  logic [1:0]            warnFire;
  logic [1:0]            passFire;
  logic [8:0]            cnt [2];
  logic                  schedTick;
  logic [63:0]           ioPayload;
  logic [63:0]           errPayload;
  logic                  rdHit;
  logic [31:0]           rdWord;
  logic [31:0]           perWord;

  // Period merge kept outside the case: a call result cannot be sliced
  assign perWord = mergeStrb({16'h0000, s.period}, s.wData, s.wStrb);

  assign cnt[0]     = tec;
  assign cnt[1]     = {1'b0, rec};
  assign ioPayload  = {gpioValue, analogData, 16'h0000};
  assign errPayload = {errorFlagByte, tec[7:0], rec, 40'h00_0000_0000};

  assign s_axi_awready = !s.awHave && !s.bValid;
  assign s_axi_wready  = !s.wHave && !s.bValid;
  assign s_axi_bvalid  = s.bValid;
  assign s_axi_bresp   = s.bResp;
  assign s_axi_arready = !s.rValid;
  assign s_axi_rvalid  = s.rValid;
  assign s_axi_rresp   = s.rResp;
  assign s_axi_rdata   = s.rData;
  assign reqAccept     = s.reqAcc;
  assign cmdAccept     = s.cmdAcc;
  assign txValid       = s.txSt == catx_pkg::TX_OFFER;
  assign txMsg         = s.msg;

  always_comb begin
    rdHit  = 1'b1;
    rdWord = 32'h0000_0000;
    case (s_axi_araddr)
      `CATX_OFF_STATUS_MSG_IDENTIFIER:  rdWord = s.txIdent[0];
      `CATX_OFF_RESPONSE_MSG_IDENTIFIER:  rdWord = s.txIdent[1];
      `CATX_OFF_EVENT_MSG_IDENTIFIER:  rdWord = s.txIdent[2];
      `CATX_OFF_MASK:   rdWord = s.mask;
      `CATX_OFF_FILT0:  rdWord = s.filt[0];
      `CATX_OFF_FILT1:  rdWord = s.filt[1];
      `CATX_OFF_CTRL:   rdWord = {28'h000_0000, s.ctrl};
      `CATX_OFF_PERIOD: rdWord = {16'h0000, s.period};
      `CATX_OFF_STATUS: rdWord = {21'h00_0000, s.passArm, s.warnArm,
                                  s.pend, txValid};
      default:          rdHit  = 1'b0;
    endcase
  end

  always_comb begin
    n         = s;
    clrV      = 6'h00;
    schedTick = 1'b0;
    n.reqAcc  = rxValid && matchId(rxId, s.mask, s.filt[0],
                                   s.ctrl[`CATX_CTRL_MESSAGE_TYPE_SELECT]);  // [R19]
    n.cmdAcc  = rxValid && matchId(rxId, s.mask, s.filt[1],
                                   s.ctrl[`CATX_CTRL_MESSAGE_TYPE_SELECT]);  // [R19]

    // Waking restarts the interval rather than firing it
    if (!s.ctrl[`CATX_CTRL_SCHED_EN] || wakeUp) begin  // [R3]
      n.timer = 16'h0000;
    end else if (s.timer >= s.period) begin
      n.timer   = 16'h0000;
      schedTick = 1'b1;  // [R1]
    end else begin
      n.timer = s.timer + 16'h0001;
    end

    // Hysteresis: one arm bit per threshold per counter
    for (int i = 0; i < 2; i++) begin
      warnFire[i] = s.warnArm[i] && (cnt[i] > `CATX_WARN_HI);  // [R10]
      passFire[i] = s.passArm[i] && (cnt[i] > `CATX_PASS_HI);  // [R10]
      if (warnFire[i]) begin
        n.warnArm[i] = 1'b0;  // [R24]
      end else if (cnt[i] <= `CATX_WARN_LO) begin
        n.warnArm[i] = 1'b1;  // [R11]
      end
      if (passFire[i]) begin
        n.passArm[i] = 1'b0;  // [R24]
      end else if (cnt[i] <= `CATX_PASS_LO) begin
        n.passArm[i] = 1'b1;  // [R12]
      end
    end

    setV                   = 6'h00;
    setV[`CATX_PEND_SCHED] = schedTick;
    setV[`CATX_PEND_ACK]   = cmdDone && s.ctrl[`CATX_CTRL_ACKSEL];  // [R8]
    setV[`CATX_PEND_OVF]   = rxOverflow && !s.ctrl[`CATX_CTRL_ACKSEL];  // [R9]
    setV[`CATX_PEND_ERR]   = |{warnFire, passFire};  // [R6]
    setV[`CATX_PEND_EVENT] = inputEdge || analogCross || wakeOnChange;  // [R14]

    // Error first, status last; one message offered at a time
    case (s.txSt)
      catx_pkg::TX_IDLE: begin
        if (s.pend[`CATX_PEND_ERR]) begin
          n.msg = buildMsg(catx_pkg::KIND_ERR, s.txIdent[1],
                           `CATX_DLC_ERR, errPayload);  // [R4] [R6]
          clrV[`CATX_PEND_ERR] = 1'b1;
        end else if (s.pend[`CATX_PEND_OVF]) begin
          n.msg = buildMsg(catx_pkg::KIND_OVF, s.txIdent[1],
                           `CATX_DLC_NONE, 64'h0);  // [R4] [R5]
          clrV[`CATX_PEND_OVF] = 1'b1;
        end else if (s.pend[`CATX_PEND_ACK]) begin
          n.msg = buildMsg(catx_pkg::KIND_ACK, s.txIdent[1],
                           `CATX_DLC_NONE, 64'h0);  // [R4] [R5]
          clrV[`CATX_PEND_ACK] = 1'b1;
        end else if (s.pend[`CATX_PEND_EVENT]) begin
          n.msg = buildMsg(catx_pkg::KIND_EVENT, s.txIdent[2],
                           `CATX_DLC_IO, ioPayload);  // [R13]
          clrV[`CATX_PEND_EVENT] = 1'b1;
        end else if (s.pend[`CATX_PEND_POWER]) begin
          n.msg = buildMsg(catx_pkg::KIND_POWER, s.txIdent[0],
                           `CATX_DLC_NONE, 64'h0);  // [R7]
          clrV[`CATX_PEND_POWER] = 1'b1;
        end else if (s.pend[`CATX_PEND_SCHED]) begin
          if (s.ctrl[`CATX_CTRL_PAYLOAD]) begin
            n.msg = buildMsg(catx_pkg::KIND_SCHED, s.txIdent[0],
                             `CATX_DLC_IO, ioPayload);  // [R1] [R2]
          end else begin
            n.msg = buildMsg(catx_pkg::KIND_SCHED, s.txIdent[0],
                             `CATX_DLC_NONE, 64'h0);  // [R1]
          end
          clrV[`CATX_PEND_SCHED] = 1'b1;
        end
        if (|s.pend) begin
          n.txSt = catx_pkg::TX_OFFER;
        end
      end
      catx_pkg::TX_OFFER: begin
        if (txReady) begin
          n.txSt = catx_pkg::TX_IDLE;
        end
      end
      default: n.txSt = catx_pkg::TX_IDLE;
    endcase
    // A trigger in the loading cycle survives the clear
    n.pend = (s.pend & ~clrV) | setV;

    // Register write path
    if (s_axi_awvalid && s_axi_awready) begin
      n.awHave = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.wHave = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (s.bValid && s_axi_bready) begin
      n.bValid = 1'b0;
    end
    if (s.awHave && s.wHave) begin
      n.awHave = 1'b0;
      n.wHave  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = `CATX_RESP_OKAY;
      case (s.awAddr)
        `CATX_OFF_STATUS_MSG_IDENTIFIER:  n.txIdent[0] = mergeStrb(s.txIdent[0], s.wData,
                                          s.wStrb) & `CATX_ID_CLEAN;
        `CATX_OFF_RESPONSE_MSG_IDENTIFIER:  n.txIdent[1] = mergeStrb(s.txIdent[1], s.wData,
                                          s.wStrb) & `CATX_ID_CLEAN;
        `CATX_OFF_EVENT_MSG_IDENTIFIER:  n.txIdent[2] = mergeStrb(s.txIdent[2], s.wData,
                                          s.wStrb) & `CATX_ID_CLEAN;
        `CATX_OFF_MASK:   n.mask = mergeStrb(s.mask, s.wData,
                                          s.wStrb) & `CATX_MASK_CLEAN;
        `CATX_OFF_FILT0:  n.filt[0] = mergeStrb(s.filt[0], s.wData,
                                          s.wStrb) & `CATX_ID_CLEAN;
        `CATX_OFF_FILT1:  n.filt[1] = mergeStrb(s.filt[1], s.wData,
                                          s.wStrb) & `CATX_ID_CLEAN;
        `CATX_OFF_CTRL: begin
          if (s.wStrb[0]) begin
            n.ctrl = s.wData[3:0];
          end
        end
        `CATX_OFF_PERIOD: n.period = perWord[15:0];
        `CATX_OFF_STATUS: n.bResp = `CATX_RESP_OKAY;
        default:          n.bResp = `CATX_RESP_SLVERR;
      endcase
    end

    // Register read path
    if (s.rValid && s_axi_rready) begin
      n.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rValid = 1'b1;
      n.rData  = rdWord;
      n.rResp  = rdHit ? `CATX_RESP_OKAY : `CATX_RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s                    <= '0;
      s.txIdent            <= {3{`CATX_RST_WORD}};
      s.mask               <= `CATX_RST_WORD;
      s.filt               <= {2{`CATX_RST_WORD}};
      s.ctrl               <= `CATX_RST_CTRL;
      s.period             <= `CATX_RST_PERIOD;
      s.pend               <= 6'h02;  // [R7]
      s.warnArm            <= 2'h3;
      s.passArm            <= 2'h3;
      s.txSt               <= catx_pkg::TX_IDLE;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSyncB);

  sequence warnCross0;
    s.warnArm[0] && (tec > `CATX_WARN_HI);
  endsequence

  sequence errQueued;
    !s.warnArm[0] && (s.pend[`CATX_PEND_ERR] ||
                      (txValid && s.msg.kind == catx_pkg::KIND_ERR));
  endsequence

  a_warn_fires: assert property (warnCross0 |=> errQueued)  // [R10]
    else $error("warning crossing did not queue error message");

  a_warn_rearm: assert property (
      !s.warnArm[0] && (tec > `CATX_WARN_LO) |=> !s.warnArm[0])  // [R11]
    else $error("warning re-armed above low threshold");

  a_pass_rearm: assert property (
      !s.passArm[1] && ({1'b0, rec} > `CATX_PASS_LO)
      |=> !s.passArm[1])  // [R12]
    else $error("passive re-armed above low threshold");

  a_resp_dlc: assert property (
      txValid && (s.msg.kind inside {catx_pkg::KIND_ACK,
                  catx_pkg::KIND_OVF}) |-> s.msg.dlc == 4'h0)  // [R5]
    else $error("ack or overflow message with data");

  a_err_dlc: assert property (
      txValid && s.msg.kind == catx_pkg::KIND_ERR
      |-> s.msg.dlc == 4'h3 && s.msg.data[63:56] == $past(errorFlagByte))
    else $error("error message layout wrong");  // [R6]

  a_resp_ident: assert property (
      $rose(txValid) && (s.msg.kind inside {catx_pkg::KIND_ACK,
      catx_pkg::KIND_OVF, catx_pkg::KIND_ERR})
      |-> s.msg.sid == $past(s.txIdent[1][31:21]))  // [R4]
    else $error("response message used wrong identifier");

  a_event_ident: assert property (
      $rose(txValid) && s.msg.kind == catx_pkg::KIND_EVENT
      |-> s.msg.eid == $past({s.txIdent[2][17:16], s.txIdent[2][15:0]}))
    else $error("event message used wrong identifier");  // [R13]

  a_power_once: assert property (
      !s.pend[`CATX_PEND_POWER] |=> !s.pend[`CATX_PEND_POWER])  // [R7]
    else $error("power-up message queued twice");

  a_ack_queue: assert property (
      cmdDone && s.ctrl[`CATX_CTRL_ACKSEL] |=> s.pend[`CATX_PEND_ACK])
    else $error("processed command not acknowledged");  // [R8]

  a_drop_nomatch: assert property (
      rxValid && !matchId(rxId, s.mask, s.filt[1],
                          s.ctrl[`CATX_CTRL_MESSAGE_TYPE_SELECT]) |=> !cmdAccept)
    else $error("non-matching frame accepted");  // [R20]

  a_hold_offer: assert property (
      txValid && !txReady |=> txValid && $stable(txMsg))  // [R21]
    else $error("offered message changed before taken");

endmodule

// *** tb/catx_can_node.sv ***
// Far-side CAN node model that takes offered frames and records them.
// Assumes the block holds txValid and txMsg until txReady is sampled.
`timescale 1ns/1ns

module catx_can_node (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // Frame offered by the block
  input  wire logic                  txValid,
  input  wire catx_pkg::catx_txmsg_s txMsg,
  output logic                       txReady,
  // Control and record
  input  wire logic                  slow,
  output catx_pkg::catx_txmsg_s      gotMsg,
  output logic [7:0]                 gotCnt
);

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] waitQ;

  // Slow mode stalls three cycles, as after lost arbitration
  assign txReady = txValid && (!slow || waitQ == 2'h3);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitQ <= 2'h0;
      gotCnt <= 8'h00;
      gotMsg <= '0;
    end else begin
      waitQ <= (txValid && !txReady) ? waitQ + 2'h1 : 2'h0;
      if (txValid && txReady) begin
        gotMsg <= txMsg;
        gotCnt <= gotCnt + 8'h01;
      end
    end
  end

endmodule

// *** tb/catx_top_test.sv ***
// Self-checking bench for the identifier and acceptance block.
// Assumes the CAN node model and the block's package are compiled first.
`timescale 1ns/1ns

module catx_top_test;

  ////////////////////////////////////////////////////////////////////////
  logic ref_clk, rst_b, slow, rxValid, bready, rready;
  logic awvalid, wvalid, arvalid, awready, wready, arready, bvalid, rvalid;
  logic [7:0] awaddr, araddr, rec, eflag, gpio, gotCnt, seenCnt;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [5:0] trig;
  logic [8:0] tec;
  logic [39:0] analog;
  logic reqAccept, cmdAccept, txValid, txReady;
  catx_pkg::catx_rxid_s rxId;
  catx_pkg::catx_txmsg_s txMsg, gotMsg;
  int errCount, testsRun;
  localparam logic [31:0] ID0 = 32'h1234_0000;
  localparam logic [31:0] ID1 = 32'hAB80_1234;
  localparam logic [31:0] ID2 = 32'h5A2B_C3D4;
  localparam logic [63:0] IOD = {8'h3C, 40'h12_3456_789A, 16'h0000};

  catx_top i_catx_top (.ref_clk(ref_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxValid(rxValid),
    .rxId(rxId), .reqAccept(reqAccept), .cmdAccept(cmdAccept),
    .cmdDone(trig[0]), .rxOverflow(trig[1]), .inputEdge(trig[2]),
    .analogCross(trig[3]), .wakeUp(trig[4]), .wakeOnChange(trig[5]),
    .tec(tec), .rec(rec), .errorFlagByte(eflag), .gpioValue(gpio),
    .analogData(analog), .txValid(txValid), .txReady(txReady),
    .txMsg(txMsg));

  catx_can_node i_catx_can_node (.ref_clk(ref_clk), .rst_b(rst_b),
    .txValid(txValid), .txMsg(txMsg), .txReady(txReady), .slow(slow),
    .gotMsg(gotMsg), .gotCnt(gotCnt));

  ////////////////////////////////////////////////////////////////////////
  task summarize;
    begin
      $display("checks %0d errors %0d", testsRun, errCount);
      if (errCount == 0 && testsRun > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask

  task chk(input logic [127:0] g, input logic [127:0] e, input string m);
    begin
      testsRun++;
      if (g !== e) begin
        errCount++;
        $display("[ERR] %0t %s got %0h exp %0h", $time, m, g, e);
      end
    end
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic t1, t2, t3;
    logic [1:0] got;
    begin
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(negedge ref_clk);
        t1 = awvalid && awready;
        t2 = wvalid && wready;
        t3 = bvalid;
        got = bresp;
        @(posedge ref_clk);
        if (t1) awvalid <= 1'b0;
        if (t2) wvalid <= 1'b0;
      end while (!t3);
      bready <= 1'b0;
      chk(got, r, "write response");
    end
  endtask

  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic t1, t3;
    logic [33:0] got;
    begin
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(negedge ref_clk);
        t1 = arvalid && arready;
        t3 = rvalid;
        got = {rresp, rdata};
        @(posedge ref_clk);
        if (t1) arvalid <= 1'b0;
      end while (!t3);
      rready <= 1'b0;
      chk(got, {r, d}, "read");
    end
  endtask

  task pulse(input int i);
    begin
      @(posedge ref_clk);
      trig <= 6'h01 << i;
      @(posedge ref_clk);
      trig <= 6'h00;
    end
  endtask

  task noMsg(input int n);
    begin
      repeat (n) @(posedge ref_clk);
      chk(gotCnt, seenCnt, "unexpected frame");
    end
  endtask

  task expMsg(input catx_pkg::catx_kind_e k, input logic [31:0] w,
              input logic [3:0] l, input logic [63:0] d);
    catx_pkg::catx_txmsg_s e;
    int n;
    begin
      n = 0;
      while (gotCnt === seenCnt && n < 300) begin
        @(posedge ref_clk);
        n++;
      end
      seenCnt = gotCnt;
      e = gotMsg;
      e.kind = k;
      e.ext = w[19];
      e.sid = w[31:21];
      e.dlc = l;
      if (w[19]) e.eid = {w[17:16], w[15:0]};
      e.data = d;
      chk(n < 300, 1'b1, "frame wait");
      chk(gotMsg, e, "frame");
    end
  endtask

  task rxChk(input logic x, input logic [10:0] s, input logic [1:0] ex);
    begin
      @(posedge ref_clk);
      rxId <= {x, s, 18'h2_5A5A};
      rxValid <= 1'b1;
      @(posedge ref_clk);
      rxValid <= 1'b0;
      #1;
      chk({reqAccept, cmdAccept}, ex, "accept");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task tPower;
    begin
      expMsg(catx_pkg::KIND_POWER, 32'h0, 4'h0, 64'h0);
      pulse(4);
      noMsg(40);
    end
  endtask

  task tRegs;
    begin
      axr(8'h00, 32'h0, 2'h0);
      axw(8'h00, ID0, 2'h0);
      axw(8'h04, ID1, 2'h0);
      axw(8'h08, ID2, 2'h0);
      axr(8'h08, ID2, 2'h0);
      axw(8'h0C, 32'hFFE0_0007, 2'h0);
      axr(8'h0C, 32'hFFE0_0000, 2'h0);
      axw(8'h10, 32'h2460_0000, 2'h0);
      axw(8'h14, 32'hFFE0_0000, 2'h0);
      axr(8'h3C, 32'h0, 2'h2);
      axw(8'h3C, 32'h1, 2'h2);
    end
  endtask

  task tResp;
    begin
      slow <= 1'b1;
      axw(8'h18, 32'h4, 2'h0);
      pulse(0);
      expMsg(catx_pkg::KIND_ACK, ID1, 4'h0, 64'h0);
      axw(8'h18, 32'h0, 2'h0);
      pulse(0);
      noMsg(20);
      pulse(1);
      expMsg(catx_pkg::KIND_OVF, ID1, 4'h0, 64'h0);
      slow <= 1'b0;
    end
  endtask

  task tErr;
    begin
      tec <= 9'd96;
      expMsg(catx_pkg::KIND_ERR, ID1, 4'h3, 64'hA560_0000_0000_0000);
      tec <= 9'd80;
      noMsg(5);
      tec <= 9'd96;
      noMsg(20);
      tec <= 9'd79;
      noMsg(5);
      tec <= 9'd96;
      expMsg(catx_pkg::KIND_ERR, ID1, 4'h3, 64'hA560_0000_0000_0000);
      rec <= 8'd128;
      expMsg(catx_pkg::KIND_ERR, ID1, 4'h3, 64'hA560_8000_0000_0000);
      noMsg(20);
      rec <= 8'd112;
      noMsg(5);
      rec <= 8'd128;
      noMsg(20);
      rec <= 8'd111;
      noMsg(5);
      rec <= 8'd128;
      expMsg(catx_pkg::KIND_ERR, ID1, 4'h3, 64'hA560_8000_0000_0000);
    end
  endtask

  task tEvent;
    begin
      pulse(2);
      expMsg(catx_pkg::KIND_EVENT, ID2, 4'h6, IOD);
      pulse(3);
      expMsg(catx_pkg::KIND_EVENT, ID2, 4'h6, IOD);
      pulse(5);
      expMsg(catx_pkg::KIND_EVENT, ID2, 4'h6, IOD);
    end
  endtask

  task tFilter;
    begin
      rxChk(1'b0, 11'h124, 2'h2);
      rxChk(1'b0, 11'h133, 2'h0);
      rxChk(1'b1, 11'h123, 2'h2);
      rxChk(1'b1, 11'h124, 2'h0);
      rxChk(1'b0, 11'h7F8, 2'h1);
      rxChk(1'b0, 11'h12B, 2'h0);
      axw(8'h18, 32'h8, 2'h0);
      rxChk(1'b0, 11'h12B, 2'h2);
      axw(8'h0C, 32'hFFE8_0000, 2'h0);
      rxChk(1'b1, 11'h123, 2'h0);
      rxChk(1'b0, 11'h123, 2'h2);
    end
  endtask

  task tSched;
    begin
      axw(8'h1C, 32'd10, 2'h0);
      axw(8'h18, 32'h3, 2'h0);
      expMsg(catx_pkg::KIND_SCHED, ID0, 4'h6, IOD);
      expMsg(catx_pkg::KIND_SCHED, ID0, 4'h6, IOD);
      axw(8'h18, 32'h0, 2'h0);
      axw(8'h18, 32'h1, 2'h0);
      expMsg(catx_pkg::KIND_SCHED, ID0, 4'h0, 64'h0);
      axw(8'h18, 32'h0, 2'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Whole run needs about 350 cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    errCount++;
    summarize;
  end

  initial begin
    {rst_b, slow, rxValid, bready, rready, awvalid, wvalid, arvalid} = '0;
    {awaddr, araddr, wdata, trig, tec, rec, seenCnt} = '0;
    rxId = '0;
    eflag = 8'hA5;
    gpio = 8'h3C;
    analog = 40'h12_3456_789A;
    errCount = 0;
    testsRun = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    tPower;
    tRegs;
    tResp;
    tErr;
    tEvent;
    tFilter;
    tSched;
    summarize;
  end

endmodule
